//--- omp_diag.sv
// package of shared constants and the diagnostics controller for the management port
package omp_pkg;
  // =====================================================================
  // two-wire slave
  localparam logic [6:0]  DEV_ADDR    = 7'h50;   // bus address of the memory
  localparam int          ADDR_W      = 7;       // byte address width
  localparam logic [6:0]  WP_LIMIT    = 7'h10;   // bytes below this are read-only
  localparam int          MAP_BYTES   = 16;      // live diagnostic bytes
  localparam int          RAM_DEPTH   = 112;     // writable bytes above the limit
  localparam logic [5:0]  SYNC_RST    = 6'h03;   // scl and sda idle high
  localparam logic [4:0]  NR_CYCLES   = 5'h10;   // not-ready hold after a reset
  // =====================================================================
  // live map offsets
  localparam int          OFS_TEMP    = 'h00;    // two bytes each, high byte first
  localparam int          OFS_ALARM   = 'h0A;
  localparam int          OFS_WARN    = 'h0B;
  localparam int          OFS_STATUS  = 'h0C;
  localparam int          BIT_LOS     = 0;       // status byte bit positions
  localparam int          BIT_NR      = 1;
  localparam int          BIT_LASOFF  = 2;
  localparam int          BIT_STBY    = 3;
  // =====================================================================
  // factory limits, index 0 temperature, 1 bias, 2 tx power, 3 rx power, 4 supply
  localparam logic [4:0][15:0] ALARM_HI = {16'hF000, 16'hF000, 16'hF000, 16'hF000, 16'hF000};
  localparam logic [4:0][15:0] ALARM_LO = {16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000};
  localparam logic [4:0][15:0] WARN_HI  = {16'hE000, 16'hE000, 16'hE000, 16'hE000, 16'hE000};
  localparam logic [4:0][15:0] WARN_LO  = {16'h2000, 16'h2000, 16'h2000, 16'h2000, 16'h2000};
endpackage

`timescale 1ns/1ns
module omp_diag (
  input  wire logic                 clk_sys_in,
  input  wire logic                 nrst_in,
  input  wire logic [4:0][15:0]     monitor_in,
  input  wire logic                 rx_lost_in,
  input  wire logic                 not_ready_in,
  input  wire logic                 laser_off_in,
  input  wire logic                 standby_in,
  output logic      [15:0][7:0]     map_out,
  output logic                      int_req_out
);
  logic [4:0][15:0] val_r;
  logic [4:0]       alarm_w;
  logic [4:0]       warn_w;
  logic [15:0][7:0] map_nxt;

  // true when a value lies outside the given window
  function automatic logic out_of(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    out_of = (v > hi) || (v < lo);
  endfunction

  // =====================================================================
  // limit checks on the latched values
  // range flags
  for (genvar i = 0; i < 5; i++) begin : g_chk
    assign alarm_w[i] = out_of(val_r[i], omp_pkg::ALARM_LO[i], omp_pkg::ALARM_HI[i]);
    assign warn_w[i]  = out_of(val_r[i], omp_pkg::WARN_LO[i], omp_pkg::WARN_HI[i]);
  end

  // assemble the readable map
  always_comb begin
    map_nxt = '0;
    for (int i = 0; i < 5; i++) begin
      map_nxt[omp_pkg::OFS_TEMP + 2 * i]     = val_r[i][15:8];
      map_nxt[omp_pkg::OFS_TEMP + 2 * i + 1] = val_r[i][7:0];
    end
    map_nxt[omp_pkg::OFS_ALARM] = {3'h0, alarm_w};
    map_nxt[omp_pkg::OFS_WARN]  = {3'h0, warn_w};
    map_nxt[omp_pkg::OFS_STATUS][omp_pkg::BIT_LOS]    = rx_lost_in;
    map_nxt[omp_pkg::OFS_STATUS][omp_pkg::BIT_NR]     = not_ready_in;
    map_nxt[omp_pkg::OFS_STATUS][omp_pkg::BIT_LASOFF] = laser_off_in;
    map_nxt[omp_pkg::OFS_STATUS][omp_pkg::BIT_STBY]   = standby_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      val_r       <= '0;
      map_out     <= '0;
      int_req_out <= 1'b0;
    end else begin
      val_r       <= monitor_in;
      map_out     <= map_nxt;
      int_req_out <= (|alarm_w) || (|warn_w) || rx_lost_in;
    end
  end

  // =====================================================================
  // checks
  // the two stages must both have left reset before the lag can be checked
  a_value_live: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    nrst_in && $past(nrst_in)
    |-> ##2 map_out[omp_pkg::OFS_TEMP + 1] == $past(monitor_in[0][7:0], 2))
    else $error("temperature byte does not follow the monitor");
  a_alarm_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (val_r[0] > omp_pkg::ALARM_HI[0]) |=> map_out[omp_pkg::OFS_ALARM][0] && int_req_out)
    else $error("high temperature did not raise its alarm");
endmodule

//--- omp_port.sv
// management port of the optical module: two-wire slave, memory and control pins
`timescale 1ns/1ns
module omp_port (
  input  wire logic                 clk_sys_in,
  input  wire logic                 nrst_in,
  input  wire logic                 deselect_in,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_out,
  output logic                      int_n_out,
  input  wire logic                 laser_off_request_in,
  output logic                      laser_off_out,
  output logic                      module_absent_out,
  input  wire logic                 power_down_in,
  output logic                      standby_out,
  output logic                      module_not_ready_ind_out,
  input  wire logic                 rx_light_in,
  output logic                      rx_signal_lost_ind_out,
  input  wire logic                 ref_clock_in_p,
  input  wire logic                 ref_clock_in_n,
  input  wire logic [4:0][15:0]     monitor_in
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK, ST_RLOAD
  } omp_state_t;

  logic [5:0]       meta_r;
  logic [5:0]       sync_r;
  logic [5:0]       dly_r;
  omp_state_t       st_r;
  omp_state_t       after_r;
  logic [2:0]       cnt_r;
  logic [7:0]       shift_r;
  logic             oe_r;
  logic             ack_ph_r;
  logic [6:0]       ptr_r;
  logic [7:0]       ram_r [omp_pkg::RAM_DEPTH];
  logic [4:0]       nr_cnt_r;
  logic             nr_r;
  logic             standby_r;
  logic             laser_off_r;
  logic             los_r;
  logic [15:0][7:0] map_w;
  logic             int_req_w;

  // =====================================================================
  // input synchronisers and edge detection
  wire [5:0] raw_w = {rx_light_in, laser_off_request_in, power_down_in,
                      deselect_in, sda_in, scl_in};

  // two flops per pin, then one delay flop for edges
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      meta_r <= omp_pkg::SYNC_RST;
      sync_r <= omp_pkg::SYNC_RST;
      dly_r  <= omp_pkg::SYNC_RST;
    end else begin
      meta_r <= raw_w;
      sync_r <= meta_r;
      dly_r  <= sync_r;
    end
  end

  wire scl_s       = sync_r[0];
  wire sda_s       = sync_r[1];
  wire desel_s     = sync_r[2];
  wire pd_s        = sync_r[3];
  wire laser_req_s = sync_r[4];
  wire light_s     = sync_r[5];
  wire scl_rise    = scl_s & ~dly_r[0];
  wire scl_fall    = ~scl_s & dly_r[0];
  wire start_w     = scl_s & dly_r[0] & ~sda_s & dly_r[1];
  wire stop_w      = scl_s & dly_r[0] & sda_s & ~dly_r[1];
  wire pd_fall     = ~pd_s & dly_r[3];
  wire mod_rst     = ~nrst_in | pd_fall;

  // =====================================================================
  // byte decode and memory access
  wire             last_bit  = (cnt_r == 3'h7);
  wire [7:0]       rx_byte_w = {shift_r[6:0], sda_s};
  wire             ctl_evt   = desel_s | stop_w | start_w;
  wire             low_area  = (ptr_r < omp_pkg::WP_LIMIT);
  wire [6:0]       ram_idx   = 7'(ptr_r - omp_pkg::WP_LIMIT);
  wire [7:0]       rd_byte_w = low_area ? map_w[ptr_r[3:0]] : ram_r[ram_idx];
  // writes only above the protected bytes
  wire             mem_we    = (st_r == ST_WDATA) & scl_rise & last_bit & ~ctl_evt
                               & ~low_area;
  wire             addr_hit  = (rx_byte_w[7:1] == omp_pkg::DEV_ADDR);

  // =====================================================================
  // two-wire slave sequencer
  always_ff @(posedge clk_sys_in) begin
    if (mod_rst) begin
      st_r     <= ST_IDLE;
      after_r  <= ST_IDLE;
      cnt_r    <= 3'h0;
      shift_r  <= 8'h00;
      oe_r     <= 1'b0;
      ack_ph_r <= 1'b0;
      ptr_r    <= 7'h00;
    end else if (desel_s || stop_w) begin
      st_r <= ST_IDLE;
      oe_r <= 1'b0;
    end else if (start_w) begin
      st_r  <= ST_ADDR;
      cnt_r <= 3'h0;
      oe_r  <= 1'b0;
    end else begin
      case (st_r)
        // shift in on the rising edge
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_r  <= rx_byte_w;
            cnt_r    <= 3'(cnt_r + 3'h1);
            ack_ph_r <= 1'b0;
            if (last_bit) begin
              st_r <= ST_ACK;
              if (st_r == ST_ADDR) begin
                after_r <= rx_byte_w[0] ? ST_RLOAD : ST_PTR;
                if (!addr_hit) begin
                  st_r <= ST_IDLE;
                end
              end else if (st_r == ST_PTR) begin
                ptr_r   <= rx_byte_w[6:0];
                after_r <= ST_WDATA;
              end else begin
                ptr_r   <= 7'(ptr_r + 7'h01);
                after_r <= ST_WDATA;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!ack_ph_r) begin
              oe_r     <= 1'b1;
              ack_ph_r <= 1'b1;
            end else if (after_r == ST_RLOAD) begin
              oe_r    <= ~rd_byte_w[7];
              shift_r <= {rd_byte_w[6:0], 1'b0};
              cnt_r   <= 3'h0;
              st_r    <= ST_RDATA;
            end else begin
              oe_r  <= 1'b0;
              cnt_r <= 3'h0;
              st_r  <= after_r;
            end
          end
        end
        // next bit after the falling edge
        ST_RDATA: begin
          if (scl_fall) begin
            oe_r    <= ~shift_r[7];
            shift_r <= {shift_r[6:0], 1'b0};
          end else if (scl_rise) begin
            cnt_r <= 3'(cnt_r + 3'h1);
            if (last_bit) begin
              st_r  <= ST_MACK;
              ptr_r <= 7'(ptr_r + 7'h01);
            end
          end
        end
        // host acknowledge: low continues, high ends the read
        ST_MACK: begin
          if (scl_fall) begin
            oe_r <= 1'b0;
          end else if (scl_rise) begin
            st_r <= sda_s ? ST_IDLE : ST_RLOAD;
          end
        end
        // sequential read of the next byte
        ST_RLOAD: begin
          if (scl_fall) begin
            oe_r    <= ~rd_byte_w[7];
            shift_r <= {rd_byte_w[6:0], 1'b0};
            cnt_r   <= 3'h0;
            st_r    <= ST_RDATA;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (mod_rst) begin
      for (int i = 0; i < omp_pkg::RAM_DEPTH; i++) begin
        ram_r[i] <= 8'h00;
      end
    end else if (mem_we) begin
      ram_r[ram_idx] <= rx_byte_w;
    end
  end

  // =====================================================================
  // control and status pins
  // not ready until the reset settles
  always_ff @(posedge clk_sys_in) begin
    if (mod_rst) begin
      nr_cnt_r <= 5'h00;
      nr_r     <= 1'b1;
    end else begin
      if (nr_cnt_r != omp_pkg::NR_CYCLES) begin
        nr_cnt_r <= 5'(nr_cnt_r + 5'h01);
      end
      nr_r <= (nr_cnt_r != omp_pkg::NR_CYCLES) | pd_s;
    end
  end

  // laser off, standby, loss of light
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      standby_r   <= 1'b0;
      laser_off_r <= 1'b1;
      los_r       <= 1'b1;
    end else begin
      standby_r   <= pd_s;
      laser_off_r <= laser_req_s | pd_s;
      los_r       <= ~light_s;
    end
  end

  // diagnostics controller holds the live map
  omp_diag u_diag (
    .clk_sys_in   (clk_sys_in),
    .nrst_in      (~mod_rst),
    .monitor_in   (monitor_in),
    .rx_lost_in   (los_r),
    .not_ready_in (nr_r),
    .laser_off_in (laser_off_r),
    .standby_in   (standby_r),
    .map_out      (map_w),
    .int_req_out  (int_req_w)
  );

  // reference clock pins are left unused
  assign sda_out                  = 1'b0;             // open drain, only the enable moves
  assign sda_oe_out               = oe_r;
  // interrupt pin from the alarm, warning and loss-of-signal flags
  assign int_n_out                = ~int_req_w;
  assign laser_off_out            = laser_off_r;
  assign module_absent_out        = 1'b0;
  assign standby_out              = standby_r;
  assign module_not_ready_ind_out = nr_r;
  assign rx_signal_lost_ind_out   = los_r;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  a_desel_idle: assert property (desel_s && !pd_fall |=> st_r == ST_IDLE && !sda_oe_out)
    else $error("transfer continued while deselected");
  a_int_follow: assert property (!int_n_out == (map_w[omp_pkg::OFS_ALARM] != 8'h00
    || map_w[omp_pkg::OFS_WARN] != 8'h00 || map_w[omp_pkg::OFS_STATUS][omp_pkg::BIT_LOS]))
    else $error("interrupt pin not low with a flag set");
  a_laser_off: assert property (laser_req_s |=> laser_off_out)
    else $error("laser stayed on under disable request");
  a_absent_low: assert property (!module_absent_out)
    else $error("absent pin not low");
  a_standby_hold: assert property (pd_s |=> standby_out && laser_off_out)
    else $error("no standby while powered down");
  a_pd_reset: assert property (pd_fall |=> st_r == ST_IDLE && ptr_r == 7'h00 && nr_r)
    else $error("power-down release did not reset");
  a_write_prot: assert property (st_r == ST_WDATA && scl_rise && last_bit && !ctl_evt
    |-> mem_we == (ptr_r >= omp_pkg::WP_LIMIT))
    else $error("write into protected bytes");
  a_ram_store: assert property (mem_we && !mod_rst
    |=> ram_r[$past(ram_idx)] == $past(rx_byte_w))
    else $error("written byte not stored");
  a_sda_timing: assert property ($changed(sda_oe_out) && !$past(mod_rst)
    |-> $past(scl_fall) || $past(ctl_evt))
    else $error("sda moved away from falling scl");
  a_start_addr: assert property (start_w && !desel_s && !stop_w && !mod_rst
    |=> st_r == ST_ADDR && cnt_r == 3'h0)
    else $error("start not detected");
  a_ptr_step: assert property (st_r == ST_RDATA && scl_rise && last_bit && !ctl_evt
    && !mod_rst |=> ptr_r == 7'($past(ptr_r) + 7'h01))
    else $error("address did not advance after a byte");
  a_los_level: assert property (!light_s |=> rx_signal_lost_ind_out)
    else $error("loss of signal not reported");

  c_write: cover property (mem_we);
  c_read_more: cover property (st_r == ST_MACK && scl_rise && !sda_s);
  c_read_end: cover property (st_r == ST_MACK && scl_rise && sda_s);
  c_pd_reset: cover property (pd_fall);
endmodule

//--- omp_host.sv
// two-wire bus master model standing in for the host board controller
`timescale 1ns/1ns
module omp_host (
  input  wire logic clk_sys_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // =====================================================================
  // bus idles with both lines released high
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic bit_out(input logic b);
    tick(2);
    sda_low_out <= ~b;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
  endtask

  // data line released, sampled mid-way through the high phase
  task automatic bit_in(output logic b);
    tick(2);
    sda_low_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    b = sda_in;
    tick(2);
    scl_out <= 1'b0;
  endtask

  task automatic start();
    tick(2);
    sda_low_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_low_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_low_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_low_out <= 1'b0;
    tick(4);
  endtask

  // msb first, then the receiver's acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = ~b;
  endtask

  // host acknowledges to continue, refuses to end
  task automatic recv_byte(output logic [7:0] d, input logic more);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(~more);
  endtask
endmodule

//--- tb_omp_port.sv
// self-checking bench for the optical module management port
`timescale 1ns/1ns
module tb_omp_port;
  logic             clk_sys_in  = 1'b0;
  logic             nrst_in     = 1'b0;
  logic             deselect_in = 1'b0;
  logic             laser_req   = 1'b0;
  logic             power_down  = 1'b0;
  logic             rx_light    = 1'b1;
  logic [4:0][15:0] monitor;
  wire              scl, host_low, sda_wire, sda_out, sda_oe, int_n, laser_off;
  wire              absent, standby, not_ready, los;
  int               num_errors  = 0;
  int               num_checks  = 0;
  int               cycles      = 0;

  // pulled-up data line, low when either party pulls it
  assign sda_wire = ~(host_low | (sda_oe & ~sda_out));

  always #50 clk_sys_in = ~clk_sys_in;

  omp_port u_dut (
    .clk_sys_in               (clk_sys_in),
    .nrst_in                  (nrst_in),
    .deselect_in              (deselect_in),
    .scl_in                   (scl),
    .sda_in                   (sda_wire),
    .sda_out                  (sda_out),
    .sda_oe_out               (sda_oe),
    .int_n_out                (int_n),
    .laser_off_request_in     (laser_req),
    .laser_off_out            (laser_off),
    .module_absent_out        (absent),
    .power_down_in            (power_down),
    .standby_out              (standby),
    .module_not_ready_ind_out (not_ready),
    .rx_light_in              (rx_light),
    .rx_signal_lost_ind_out   (los),
    .ref_clock_in_p           (1'b0),
    .ref_clock_in_n           (1'b0),
    .monitor_in               (monitor)
  );

  omp_host u_host (
    .clk_sys_in  (clk_sys_in),
    .sda_in      (sda_wire),
    .scl_out     (scl),
    .sda_low_out (host_low)
  );

  // =====================================================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // address byte alone, acknowledge compared
  task automatic probe(input logic [7:0] a, input logic exp_ack);
    logic ack;
    u_host.start();
    u_host.send_byte(a, ack);
    u_host.stop();
    check({7'h00, ack}, {7'h00, exp_ack}, "address ack");
  endtask

  // pointer then two consecutive data bytes
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1);
    logic a0, a1, a2, a3;
    u_host.start();
    u_host.send_byte(8'hA0, a0);
    u_host.send_byte(ptr, a1);
    u_host.send_byte(d0, a2);
    u_host.send_byte(d1, a3);
    u_host.stop();
    check({4'h0, a0, a1, a2, a3}, 8'h0F, "write acks");
  endtask

  // pointer, repeated start, two consecutive reads
  task automatic rd(input logic [7:0] ptr, input logic [7:0] e0, input logic [7:0] e1);
    logic       a0, a1, a2;
    logic [7:0] d;
    u_host.start();
    u_host.send_byte(8'hA0, a0);
    u_host.send_byte(ptr, a1);
    u_host.start();
    u_host.send_byte(8'hA1, a2);
    check({5'h00, a0, a1, a2}, 8'h07, "read acks");
    u_host.recv_byte(d, 1'b1);
    check(d, e0, "first byte");
    u_host.recv_byte(d, 1'b0);
    check(d, e1, "next byte");
    u_host.stop();
  endtask

  // hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    for (int k = 0; k < 5; k++) begin
      monitor[k] = {8'h40 + 8'(k), 8'h60 + 8'(k)};
    end
    wait_clk(4);
    nrst_in <= 1'b1;
    wait_clk(25);
    check({7'h00, absent}, 8'h00, "absent pin");
    check({7'h00, los}, 8'h00, "los with light");
    check({7'h00, int_n}, 8'h01, "interrupt idle");
    check({7'h00, laser_off}, 8'h00, "laser on");
    check({7'h00, not_ready}, 8'h00, "ready after reset");
    rx_light <= 1'b0;
    wait_clk(8);
    check({7'h00, los}, 8'h01, "los without light");
    check({7'h00, int_n}, 8'h00, "interrupt on los");
    rx_light <= 1'b1;
    laser_req <= 1'b1;
    wait_clk(8);
    check({7'h00, laser_off}, 8'h01, "laser off");
    rd(8'h0C, 8'h04, 8'h00);
    laser_req <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      rd(8'(2 * k), 8'h40 + 8'(k), 8'h60 + 8'(k));
    end
    rd(8'h0A, 8'h00, 8'h00);
    wr(8'h0F, 8'hFF, 8'h5A);
    rd(8'h0F, 8'h00, 8'h5A);
    wr(8'h7F, 8'h11, 8'h22);
    rd(8'h7F, 8'h11, 8'h40);
    monitor[0] <= 16'hF800;
    monitor[1] <= 16'h0800;
    monitor[2] <= 16'h1800;
    wait_clk(8);
    check({7'h00, int_n}, 8'h00, "interrupt on flags");
    rd(8'h0A, 8'h03, 8'h07);
    monitor[0] <= 16'h4060;
    monitor[1] <= 16'h4161;
    monitor[2] <= 16'h4262;
    wait_clk(8);
    check({7'h00, int_n}, 8'h01, "interrupt cleared");
    probe(8'hA2, 1'b0);
    deselect_in <= 1'b1;
    probe(8'hA0, 1'b0);
    deselect_in <= 1'b0;
    probe(8'hA0, 1'b1);
    power_down <= 1'b1;
    wait_clk(8);
    check({6'h00, standby, laser_off}, 8'h03, "standby entered");
    check({7'h00, not_ready}, 8'h01, "not ready in standby");
    power_down <= 1'b0;
    wait_clk(8);
    check({7'h00, not_ready}, 8'h01, "not ready after release");
    wait_clk(22);
    check({7'h00, standby}, 8'h00, "standby left");
    check({7'h00, not_ready}, 8'h00, "ready again");
    rd(8'h0F, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule
